// ---- pkg/rag_pkg.sv ----
// constants and types for rom/ram address generation
package rag_pkg;
	localparam int PC_W        = 15;
	localparam int PAGE_OFS_W  = 11;
	localparam int TAB_W       = 16;
	localparam int RAM_AW      = 13;
	localparam int NIB_W       = 4;
	localparam int BANK_W      = 6;
	localparam int BANK_OFS_W  = 7;
	localparam int RPAGE_LSB   = 4;
	localparam int RPAGE_W     = 3;
	localparam int LUT_BASE_W  = 4;
	localparam logic [PC_W-1:0]   LUT_BASE  = 15'h4000;
	localparam logic [NIB_W-1:0]  REG_RESET = 4'h0;
	localparam int NUM_BANKS   = 40;
	localparam logic [BANK_W-1:0] LAST_BANK = 6'h27;
	localparam int RAM_WORDS   = 5120;
	// pc update kinds
	typedef enum logic [1:0] {
		RAG_PC_HOLD,
		RAG_PC_DIRECT,
		RAG_PC_FAR,
		RAG_PC_COND
	} rag_pc_op_t;
	// ram address modes
	typedef enum logic [1:0] {
		RAG_RAM_DIRECT,
		RAG_RAM_WORKREG,
		RAG_RAM_INDIRECT
	} rag_ram_mode_t;
	// page/bank and table address register selects
	typedef enum logic [2:0] {
		RAG_SEL_CODE_PAGE,
		RAG_SEL_RAM_PAGE,
		RAG_SEL_WR_PAGE,
		RAG_SEL_BANK_LOW,
		RAG_SEL_BANK_HIGH,
		RAG_SEL_TABLE_ADDR_NIBBLE0,
		RAG_SEL_TABLE_ADDR_NIBBLE1,
		RAG_SEL_TABLE_ADDR_NIBBLE2
	} rag_sel_t;
	localparam logic [2:0] RAG_SEL_TABLE_ADDR_NIBBLE3 = 3'h0;
endpackage : rag_pkg

// ---- design/rag_nibble_reg.sv ----
// one 4-bit select register with enable-gated load
`timescale 1ns/1ps
`default_nettype none
module rag_nibble_reg
	import rag_pkg::*;
#(
	parameter logic [3:0] RESET_VALUE = 4'h0,
	parameter logic [3:0] WRITE_MASK  = 4'hF
) (
	// clocking
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	// load
	input  wire logic       load,
	input  wire logic [3:0] load_data,
	// contents
	output logic      [3:0] value
);
	always_ff @(posedge clk) begin
		if (reset) begin
			value <= RESET_VALUE;
		end else if (clk_en && load) begin
			value <= load_data & WRITE_MASK;
		end
	end
endmodule : rag_nibble_reg
`default_nettype wire

// ---- design/rag_addr_gen.sv ----
// program counter, table and data ram address generation
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - direct jump loads all fifteen pc bits from instruction address
// - far jump takes pc 14..11 from code page, 10..0 from instruction
// - conditional branch replaces only pc 10..0, staying in current page
// - table element address equals (pc word minus 4000h) times four
// - table address nibbles 0..3 supply bits 3..0 up to 15..12
// - table read fetches rom nibble and writes it to addressed ram nibble
// - data ram is 5120 nibbles in 40 banks of 128
// - indirect address is bankhi*800h + banklo*80h + page*10h + pointer
// - ram page uses bits 2..0 for eight 16-nibble pages; bit 3 reserved
// - first two banks serve as sixteen working-register pages of sixteen
// - working-register address is wr page over register number, 8 bits
// - only selected wr page acts as registers; rest stays ordinary ram
// - no logical op between memory and immediate; goes via working register
// - bank code is four low and two high bits; codes 0..39 valid
// - combined move copies ram nibble to working register and accumulator
// - wr page select is 4-bit read/write, page n maps n0h..nfh
// - rom has sixteen code pages of 2048 words, chosen by code page
module rag_addr_gen
	import rag_pkg::*;
#(
	parameter int PC_WIDTH = PC_W
) (
	// clocking
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                clk_en,
	// sequencer: program counter
	input  wire rag_pc_op_t          pc_op,
	input  wire logic [PC_W-1:0]     instr_addr,
	input  wire logic                pc_advance,
	// sequencer: register loads
	input  wire logic                reg_load,
	input  wire logic [2:0]          reg_sel,
	input  wire logic                reg_sel_table_addr_nibble3,
	input  wire logic [NIB_W-1:0]    reg_data,
	// sequencer: data access
	input  wire logic                ram_req,
	input  wire logic                ram_write,
	input  wire rag_ram_mode_t       ram_mode,
	input  wire logic [BANK_OFS_W-1:0] instr_ram_offset,
	input  wire logic [NIB_W-1:0]    wr_number,
	input  wire logic [NIB_W-1:0]    pointer_register_indirect,
	input  wire logic [NIB_W-1:0]    ram_wdata_in,
	input  wire logic                table_read_op,
	input  wire logic                move_to_wr_and_acc,
	// program rom
	input  wire logic [TAB_W-1:0]    rom_word,
	output logic      [PC_W-1:0]     pc,
	output logic      [PC_W-1:0]     rom_addr,
	// data ram
	input  wire logic [NIB_W-1:0]    ram_rdata,
	output logic      [RAM_AW-1:0]   ram_addr,
	output logic                     ram_we,
	output logic      [NIB_W-1:0]    ram_wdata,
	output logic                     ram_addr_valid,
	// register readback and move results
	output logic      [NIB_W-1:0]    reg_rdata,
	output logic      [NIB_W-1:0]    acc_load_data,
	output logic                     acc_load,
	output logic      [NIB_W-1:0]    wr_load_data,
	output logic                     wr_load,
	output logic      [RAM_AW-1:0]   wr_load_addr
);
	logic [NIB_W-1:0]      code_page_select;
	logic [NIB_W-1:0]      ram_page_select;
	logic [NIB_W-1:0]      workreg_page_select;
	logic [NIB_W-1:0]      bank_select_low;
	logic [NIB_W-1:0]      bank_select_high;
	logic [NIB_W-1:0]      tab_nib [4];
	logic [TAB_W-1:0]      table_addr;
	logic [PC_W-1:0]       next_pc;
	logic [BANK_W-1:0]     bank_code;
	logic [RAM_AW-1:0]     next_ram_addr;
	logic [RAM_AW-1:0]     direct_addr;
	logic [RAM_AW-1:0]     workreg_addr;
	logic [RAM_AW-1:0]     indirect_addr;
	logic [PC_W-1:0]       table_pc;
	logic [NIB_W-1:0]      table_nibble;
	logic                  bank_ok;
	logic [7:0]            load_vec;
	logic                  table_addr_nibble3_load;
	logic                  table_pending;
	logic                  move_pending;
	logic [RAM_AW-1:0]     move_wr_addr;

	// one-hot register load decode
	always_comb begin
		load_vec = 8'h00;
		if (reg_load && !reg_sel_table_addr_nibble3) begin
			load_vec[reg_sel] = 1'b1;
		end
	end
	assign table_addr_nibble3_load = reg_load && reg_sel_table_addr_nibble3 && (reg_sel == RAG_SEL_TABLE_ADDR_NIBBLE3);

	// select registers, all clear on reset
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'hF)) u_code_page (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_CODE_PAGE]), .load_data(reg_data), .value(code_page_select));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'h7)) u_ram_page (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_RAM_PAGE]), .load_data(reg_data), .value(ram_page_select));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'hF)) u_wr_page (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_WR_PAGE]), .load_data(reg_data), .value(workreg_page_select));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'hF)) u_bank_low (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_BANK_LOW]), .load_data(reg_data), .value(bank_select_low));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'h3)) u_bank_high (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_BANK_HIGH]), .load_data(reg_data), .value(bank_select_high));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'hF)) u_table_addr_nibble0 (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_TABLE_ADDR_NIBBLE0]), .load_data(reg_data), .value(tab_nib[0]));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'hF)) u_table_addr_nibble1 (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_TABLE_ADDR_NIBBLE1]), .load_data(reg_data), .value(tab_nib[1]));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'hF)) u_table_addr_nibble2 (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(load_vec[RAG_SEL_TABLE_ADDR_NIBBLE2]), .load_data(reg_data), .value(tab_nib[2]));
	rag_nibble_reg #(.RESET_VALUE(REG_RESET), .WRITE_MASK(4'hF)) u_table_addr_nibble3 (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.load(table_addr_nibble3_load), .load_data(reg_data), .value(tab_nib[3]));

	// table address assembly and rom word location
	assign table_addr = {tab_nib[3], tab_nib[2], tab_nib[1], tab_nib[0]};
	assign table_pc   = LUT_BASE + {1'b0, table_addr[TAB_W-1:2]};
	always_comb begin
		case (table_addr[1:0])
			2'h0:    table_nibble = rom_word[3:0];
			2'h1:    table_nibble = rom_word[7:4];
			2'h2:    table_nibble = rom_word[11:8];
			default: table_nibble = rom_word[15:12];
		endcase
	end

	// program counter formation
	always_comb begin
		next_pc = pc;
		case (pc_op)
			RAG_PC_DIRECT: next_pc = instr_addr;
			RAG_PC_FAR:    next_pc = {code_page_select, instr_addr[PAGE_OFS_W-1:0]};
			RAG_PC_COND:   next_pc = {pc[PC_W-1:PAGE_OFS_W], instr_addr[PAGE_OFS_W-1:0]};
			default: begin
				if (pc_advance) begin
					next_pc = pc + 15'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pc <= 15'h0000;
		end else if (clk_en) begin
			pc <= next_pc;
		end
	end

	// rom address: table word during table read, otherwise fetch address
	always_ff @(posedge clk) begin
		if (reset) begin
			rom_addr <= 15'h0000;
		end else if (clk_en) begin
			rom_addr <= table_read_op ? table_pc : next_pc;
		end
	end

	// data ram address modes
	assign bank_code     = {bank_select_high[1:0], bank_select_low};
	assign bank_ok       = (bank_code <= LAST_BANK);
	assign direct_addr   = {bank_code, instr_ram_offset};
	assign workreg_addr  = {5'h00, workreg_page_select, wr_number};
	assign indirect_addr = {bank_code, ram_page_select[RPAGE_W-1:0], pointer_register_indirect};
	always_comb begin
		next_ram_addr = direct_addr;
		if (ram_mode == RAG_RAM_WORKREG) begin
			next_ram_addr = workreg_addr;
		end else if (ram_mode == RAG_RAM_INDIRECT) begin
			next_ram_addr = indirect_addr;
		end
	end

	// ram strobe; table read writes the fetched nibble next cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			ram_addr       <= 13'h0000;
			ram_we         <= 1'b0;
			ram_wdata      <= 4'h0;
			ram_addr_valid <= 1'b0;
			table_pending  <= 1'b0;
		end else if (clk_en) begin
			table_pending <= ram_req && table_read_op;
			if (table_pending) begin
				// table write obeys the same bank check as the request
				ram_we    <= ram_addr_valid;
				ram_wdata <= table_nibble;
			end else if (ram_req && !table_read_op) begin
				ram_addr       <= next_ram_addr;
				ram_addr_valid <= (ram_mode == RAG_RAM_WORKREG) || bank_ok;
				ram_we         <= ram_write && ((ram_mode == RAG_RAM_WORKREG) || bank_ok);
				ram_wdata      <= ram_wdata_in;
			end else if (ram_req) begin
				ram_addr       <= next_ram_addr;
				ram_addr_valid <= (ram_mode == RAG_RAM_WORKREG) || bank_ok;
				ram_we         <= 1'b0;
			end else begin
				ram_we         <= 1'b0;
				ram_addr_valid <= 1'b0;
			end
		end
	end

	// combined move: ram nibble to working register and accumulator
	always_ff @(posedge clk) begin
		if (reset) begin
			move_pending  <= 1'b0;
			move_wr_addr  <= 13'h0000;
			acc_load      <= 1'b0;
			wr_load       <= 1'b0;
			acc_load_data <= 4'h0;
			wr_load_data  <= 4'h0;
			wr_load_addr  <= 13'h0000;
		end else if (clk_en) begin
			move_pending <= ram_req && move_to_wr_and_acc && !ram_write;
			if (ram_req && move_to_wr_and_acc) begin
				move_wr_addr <= workreg_addr;
			end
			acc_load <= move_pending;
			wr_load  <= move_pending;
			if (move_pending) begin
				acc_load_data <= ram_rdata;
				wr_load_data  <= ram_rdata;
				wr_load_addr  <= move_wr_addr;
			end
		end
	end

	// register readback for move-from-register instructions
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 4'h0;
		end else if (clk_en) begin
			if (reg_sel_table_addr_nibble3) begin
				reg_rdata <= tab_nib[3];
			end else if (reg_sel == RAG_SEL_CODE_PAGE) begin
				reg_rdata <= code_page_select;
			end else if (reg_sel == RAG_SEL_RAM_PAGE) begin
				reg_rdata <= ram_page_select;
			end else if (reg_sel == RAG_SEL_WR_PAGE) begin
				reg_rdata <= workreg_page_select;
			end else if (reg_sel == RAG_SEL_BANK_LOW) begin
				reg_rdata <= bank_select_low;
			end else if (reg_sel == RAG_SEL_BANK_HIGH) begin
				reg_rdata <= bank_select_high;
			end else if (reg_sel == RAG_SEL_TABLE_ADDR_NIBBLE0) begin
				reg_rdata <= tab_nib[0];
			end else if (reg_sel == RAG_SEL_TABLE_ADDR_NIBBLE1) begin
				reg_rdata <= tab_nib[1];
			end else begin
				reg_rdata <= tab_nib[2];
			end
		end
	end
endmodule : rag_addr_gen
`default_nettype wire

// ---- test/rag_addr_gen_props.sv ----
// port-level assertion checker for the address generator
`timescale 1ns/1ps
`default_nettype none
module rag_addr_gen_props
	import rag_pkg::*;
(
	// clocking
	input wire logic                  clk,
	input wire logic                  reset,
	input wire logic                  clk_en,
	// sequencer
	input wire rag_pc_op_t            pc_op,
	input wire logic [PC_W-1:0]       instr_addr,
	input wire logic                  ram_req,
	input wire logic                  ram_write,
	input wire rag_ram_mode_t         ram_mode,
	input wire logic [BANK_OFS_W-1:0] instr_ram_offset,
	input wire logic [NIB_W-1:0]      wr_number,
	input wire logic [NIB_W-1:0]      pointer_register_indirect,
	input wire logic                  table_read_op,
	input wire logic                  move_to_wr_and_acc,
	// memories
	input wire logic [PC_W-1:0]       pc,
	input wire logic [PC_W-1:0]       rom_addr,
	input wire logic [NIB_W-1:0]      ram_rdata,
	input wire logic [RAM_AW-1:0]     ram_addr,
	input wire logic                  ram_we,
	// move results
	input wire logic                  acc_load,
	input wire logic [NIB_W-1:0]      acc_load_data,
	input wire logic                  wr_load,
	input wire logic [NIB_W-1:0]      wr_load_data
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_DIR: assert property (clk_en && pc_op == RAG_PC_DIRECT |=> pc == $past(instr_addr))
		else $error("direct jump pc wrong");
	AST_FAR: assert property (clk_en && pc_op == RAG_PC_FAR |=> (pc & 15'h07FF) == ($past(instr_addr) & 15'h07FF))
		else $error("far jump low bits wrong");
	AST_COND: assert property (clk_en && pc_op == RAG_PC_COND |=> $stable(pc[14:11]) && (pc & 15'h07FF) == ($past(instr_addr) & 15'h07FF))
		else $error("branch left its page");
	AST_WREG: assert property (clk_en && ram_req && ram_mode == RAG_RAM_WORKREG |=> ram_addr[12:8] == 5'h00 && ram_addr[3:0] == $past(wr_number))
		else $error("working register address wrong");
	AST_IND: assert property (clk_en && ram_req && ram_mode == RAG_RAM_INDIRECT |=> ram_addr[3:0] == $past(pointer_register_indirect))
		else $error("indirect pointer bits wrong");
	AST_DRAM: assert property (clk_en && ram_req && ram_mode == RAG_RAM_DIRECT |=> ram_addr[6:0] == $past(instr_ram_offset))
		else $error("direct offset bits wrong");
	AST_MOVE: assert property (clk_en && ram_req && move_to_wr_and_acc && !ram_write && !table_read_op |=> ##1 acc_load && wr_load && acc_load_data == $past(ram_rdata) && wr_load_data == acc_load_data)
		else $error("combined move wrong");
	AST_TAB: assert property (clk_en && ram_req && table_read_op |=> rom_addr[14])
		else $error("table word below table base");
	AST_VALID: assert property (ram_we |-> ram_addr < 13'h1400)
		else $error("write outside data ram");
	AST_RST: assert property (disable iff (1'b0) reset |=> pc == 15'h0000 && ram_we == 1'b0)
		else $error("state not cleared by reset");
endmodule : rag_addr_gen_props
bind rag_addr_gen rag_addr_gen_props u_props (.clk, .reset, .clk_en, .pc_op, .instr_addr, .ram_req, .ram_write,
	.ram_mode, .instr_ram_offset, .wr_number, .pointer_register_indirect, .table_read_op, .move_to_wr_and_acc,
	.pc, .rom_addr, .ram_rdata, .ram_addr, .ram_we, .acc_load, .acc_load_data, .wr_load, .wr_load_data);
`default_nettype wire

// ---- test/rag_mem_model.sv ----
// program rom and data ram model for the address generator
`timescale 1ns/1ps
`default_nettype none
module rag_mem_model
	import rag_pkg::*;
(
	// clocking
	input  wire logic              clk,
	// program rom
	input  wire logic [PC_W-1:0]   rom_addr,
	output logic      [TAB_W-1:0]  rom_word,
	// data ram
	input  wire logic [RAM_AW-1:0] ram_addr,
	input  wire logic              ram_we,
	input  wire logic [NIB_W-1:0]  ram_wdata,
	output logic      [NIB_W-1:0]  ram_rdata
);
	logic [NIB_W-1:0] mem [RAM_WORDS];
	// word content derived from its own address, four distinct nibbles
	assign rom_word = {rom_addr[3:0], rom_addr[7:4], ~rom_addr[11:8], 1'b0, rom_addr[14:12]};
	// outside the array the read data is the inverted write data rather than held
	assign ram_rdata = (ram_addr < RAM_WORDS) ? mem[ram_addr] : ~ram_wdata;
	always_ff @(posedge clk) begin
		if (ram_we && ram_addr < RAM_WORDS) begin
			mem[ram_addr] <= ram_wdata;
		end
	end
endmodule : rag_mem_model
`default_nettype wire

// ---- test/rag_addr_gen_tb.sv ----
// self-checking bench for the address generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module rag_addr_gen_tb
	import rag_pkg::*;
;
	logic clk, reset, clk_en, pc_advance, reg_load, reg_sel_table_addr_nibble3, ram_req, ram_write, table_read_op, move_to_wr_and_acc;
	rag_pc_op_t pc_op;
	rag_ram_mode_t ram_mode;
	logic [PC_W-1:0] instr_addr, pc, rom_addr;
	logic [2:0] reg_sel;
	logic [NIB_W-1:0] reg_data, wr_number, pointer_register_indirect, ram_wdata_in, ram_rdata, ram_wdata;
	logic [NIB_W-1:0] reg_rdata, acc_load_data, wr_load_data;
	logic [BANK_OFS_W-1:0] instr_ram_offset;
	logic [TAB_W-1:0] rom_word;
	logic [RAM_AW-1:0] ram_addr, wr_load_addr;
	logic ram_we, ram_addr_valid, acc_load, wr_load;
	int bad_count, checked;
	// mode, argument, expected ram address
	logic [21:0] rows [5] = '{{2'd0, 7'h55, 13'h12D5}, {2'd0, 7'h7F, 13'h12FF}, {2'd2, 7'h0C, 13'h12BC},
		{2'd1, 7'h06, 13'h0096}, {2'd1, 7'h0F, 13'h009F}};
	rag_addr_gen uut (.clk, .reset, .clk_en, .pc_op, .instr_addr, .pc_advance, .reg_load, .reg_sel, .reg_sel_table_addr_nibble3,
		.reg_data, .ram_req, .ram_write, .ram_mode, .instr_ram_offset, .wr_number, .pointer_register_indirect,
		.ram_wdata_in, .table_read_op, .move_to_wr_and_acc, .rom_word, .pc, .rom_addr, .ram_rdata, .ram_addr,
		.ram_we, .ram_wdata, .ram_addr_valid, .reg_rdata, .acc_load_data, .acc_load, .wr_load_data, .wr_load,
		.wr_load_addr);
	rag_mem_model mem (.clk, .rom_addr, .rom_word, .ram_addr, .ram_we, .ram_wdata, .ram_rdata);
	task results;
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	task ld(input logic [2:0] s, input logic t3, input logic [3:0] d);
		@(posedge clk);
		reg_load <= 1'b1;
		reg_sel <= s;
		reg_sel_table_addr_nibble3 <= t3;
		reg_data <= d;
		@(posedge clk);
		reg_load <= 1'b0;
		@(posedge clk);
		#1;
	endtask : ld
	task acc(input logic [1:0] m, input logic w, input logic [6:0] a, input logic t, input logic mv);
		@(posedge clk);
		ram_req <= 1'b1;
		ram_mode <= rag_ram_mode_t'(m);
		ram_write <= w;
		instr_ram_offset <= a;
		wr_number <= a[3:0];
		pointer_register_indirect <= a[3:0];
		table_read_op <= t;
		move_to_wr_and_acc <= mv;
		@(posedge clk);
		ram_req <= 1'b0;
		move_to_wr_and_acc <= 1'b0;
		#1;
	endtask : acc
	task jmp(input rag_pc_op_t op, input logic [14:0] a, input logic adv);
		@(posedge clk);
		pc_op <= op;
		instr_addr <= a;
		pc_advance <= adv;
		@(posedge clk);
		pc_op <= RAG_PC_HOLD;
		pc_advance <= 1'b0;
		#1;
	endtask : jmp
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (4000) @(posedge clk);
		bad_count++;
		results();
	end
	initial begin
		{reset, clk_en, pc_advance, reg_load, reg_sel_table_addr_nibble3, ram_req, ram_write, table_read_op} = 8'hC0;
		{move_to_wr_and_acc, instr_addr, reg_sel, reg_data, wr_number} = '0;
		{pointer_register_indirect, ram_wdata_in, instr_ram_offset} = '0;
		pc_op = RAG_PC_HOLD;
		ram_mode = RAG_RAM_DIRECT;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("pc", 15'h0000, pc)
		`CHK("code page", 4'h0, reg_rdata)
		ld(3'd2, 1'b0, 4'h9);
		`CHK("wr page", 4'h9, reg_rdata)
		ld(3'd1, 1'b0, 4'hF);
		`CHK("ram page", 4'h7, reg_rdata)
		ld(3'd4, 1'b0, 4'hE);
		`CHK("bank high", 4'h2, reg_rdata)
		ld(3'd3, 1'b0, 4'h5);
		ld(3'd0, 1'b0, 4'hA);
		ld(3'd1, 1'b0, 4'h3);
		for (int i = 0; i < 5; i++) begin
			acc(rows[i][21:20], 1'b0, rows[i][19:13], 1'b0, 1'b0);
			`CHK("ram addr", rows[i][12:0], ram_addr)
			`CHK("ram addr valid", 1'b1, ram_addr_valid)
		end
		jmp(RAG_PC_DIRECT, 15'h5ABC, 1'b0);
		`CHK("pc direct", 15'h5ABC, pc)
		`CHK("rom fetch", 15'h5ABC, rom_addr)
		jmp(RAG_PC_COND, 15'h0123, 1'b0);
		`CHK("pc cond", 15'h5923, pc)
		jmp(RAG_PC_HOLD, 15'h0000, 1'b1);
		`CHK("pc step", 15'h5924, pc)
		jmp(RAG_PC_FAR, 15'h7FFF, 1'b0);
		`CHK("pc far", 15'h57FF, pc)
		@(posedge clk);
		ram_wdata_in <= 4'hB;
		acc(2'd1, 1'b1, 7'h06, 1'b0, 1'b0);
		`CHK("wr write", 1'b1, ram_we)
		acc(2'd1, 1'b0, 7'h06, 1'b0, 1'b1);
		@(posedge clk);
		#1;
		`CHK("move", 10'h3BB, {acc_load, wr_load, acc_load_data, wr_load_data})
		`CHK("move addr", 13'h0096, wr_load_addr)
		ld(3'd5, 1'b0, 4'h5);
		ld(3'd6, 1'b0, 4'h3);
		ld(3'd7, 1'b0, 4'h2);
		ld(3'd0, 1'b1, 4'h1);
		acc(2'd1, 1'b0, 7'h00, 1'b1, 1'b0);
		`CHK("table word", 15'h448D, rom_addr)
		@(posedge clk);
		table_read_op <= 1'b0;
		#1;
		`CHK("table data", 5'h1B, {ram_we, ram_wdata})
		ld(3'd3, 1'b0, 4'hF);
		ld(3'd4, 1'b0, 4'h3);
		acc(2'd0, 1'b1, 7'h00, 1'b0, 1'b0);
		`CHK("bad bank", 2'b00, {ram_we, ram_addr_valid})
		// reset in mid-run clears the select registers again
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("pc after reset", 15'h0000, pc)
		`CHK("bank high after reset", 4'h0, reg_rdata)
		// clock enable low freezes the program counter
		@(posedge clk);
		clk_en <= 1'b0;
		jmp(RAG_PC_DIRECT, 15'h1234, 1'b0);
		`CHK("pc frozen", 15'h0000, pc)
		@(posedge clk);
		clk_en <= 1'b1;
		results();
	end
endmodule : rag_addr_gen_tb
`default_nettype wire
